// ==== design/sto_sequencer.v ====
// Soft-touch opening sequencer: switch debounce, detection timers and motor trigger.
// Function
// (RULE1) Rising debounced switch starts the opening-detection timer.
// (RULE2) Open only on release after holding longer than the opening-detection preset.
// (RULE3) Wait the dead time from the release before activating the motor.
// (RULE4) Debounce plus processing adds at most 70 ms reaction delay.
// (RULE5) Active switch means application open, inactive means closed.
// (RULE6) Falling switch while closing starts the closed-detection timer.
// (RULE7) A new opening is allowed only after the closed-detection timer expires.
// (RULE8) Switch active again before expiry clears the closed-detection timer.
// (RULE9) After a clear, the next falling switch restarts the timer from zero.
// (RULE10) All timers are system-clock counters with parameter presets, cleared on reset.
// (RULE11) Opening requests are ignored while closed timer runs or motor is active.
`timescale 1ns/1ps
`include "sto_map.vh"
module sto_sequencer #(
   parameter [`STO_CNT_W-1:0] DEB_CYC        = `STO_DEB_CYC,
   parameter [`STO_CNT_W-1:0] OPEN_DET_CYC   = `STO_OPEN_DET_CYC,
   parameter [`STO_CNT_W-1:0] CLOSED_DET_CYC = `STO_CLOSED_DET_CYC,
   parameter [`STO_CNT_W-1:0] DEAD_CYC       = `STO_DEAD_CYC,
   parameter [`STO_CNT_W-1:0] MOTOR_CYC      = `STO_MOTOR_CYC
) (
   // Clock and reset
   input  wire clk,
   input  wire rst_b,
   // Operator switch
   input  wire switch_in,
   // Motor driver and status
   output reg  motor_act_r,
   output reg  app_open_r,
   output reg  open_ready_r
);

   // One-hot phase codes; the default branch recovers from any illegal code.
   localparam [4:0] ST_CLOSED = 5'h01;
   localparam [4:0] ST_HOLD   = 5'h02;
   localparam [4:0] ST_DEAD   = 5'h04;
   localparam [4:0] ST_MOTOR  = 5'h08;
   localparam [4:0] ST_GUARD  = 5'h10;

   reg                  sw_meta_r;
   reg                  sw_sync_r;
   reg                  sw_deb_r;
   reg                  sw_prev_r;
   reg [`STO_CNT_W-1:0] deb_cnt_r;
   reg [4:0]            state_r;
   reg [4:0]            state_nxt;
   reg [`STO_CNT_W-1:0] tmr_r;
   reg [`STO_CNT_W-1:0] tmr_nxt;
   reg                  held_r;
   reg                  held_nxt;
   reg                  motor_act_nxt;
   reg                  open_ready_nxt;
   wire                 sw_rise;
   wire                 sw_fall;
   wire                 tmr_max;

   // The switch is a pin, so it is synchronised before the debouncer looks at it.
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sw_meta_r <= 1'b0;
         sw_sync_r <= 1'b0;
      end
      else
      begin
         sw_meta_r <= switch_in;
         sw_sync_r <= sw_meta_r;
      end
   end

   // A level must stay stable for DEB_CYC cycles; this bounds the reaction delay.
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         deb_cnt_r <= {`STO_CNT_W{1'b0}};
         sw_deb_r  <= 1'b0;
         sw_prev_r <= 1'b0;
      end
      else
      begin
         sw_prev_r <= sw_deb_r;
         if (sw_sync_r == sw_deb_r)
            deb_cnt_r <= {`STO_CNT_W{1'b0}};
         else if (deb_cnt_r >= DEB_CYC - 1'b1)
         begin
            deb_cnt_r <= {`STO_CNT_W{1'b0}};
            sw_deb_r  <= sw_sync_r; // see (RULE4)
         end
         else
            deb_cnt_r <= deb_cnt_r + 1'b1;
      end
   end

   assign sw_rise = sw_deb_r & ~sw_prev_r;
   assign sw_fall = ~sw_deb_r & sw_prev_r;
   assign tmr_max = (tmr_r == {`STO_CNT_W{1'b1}});

   // All phases share one counter, since only one of them runs at a time.
   always @*
   begin
      state_nxt = state_r;
      tmr_nxt   = tmr_max ? tmr_r : tmr_r + 1'b1; // see (RULE10)
      held_nxt  = held_r;
      case (state_r)
         ST_CLOSED:
         begin
            if (sw_rise)
            begin
               state_nxt = ST_HOLD; // see (RULE1)
               tmr_nxt   = {`STO_CNT_W{1'b0}};
               held_nxt  = 1'b0;
            end
         end
         ST_HOLD:
         begin
            // The held flag keeps a qualifying hold even once the timer saturates.
            if (tmr_r >= OPEN_DET_CYC)
               held_nxt = 1'b1;
            if (sw_fall)
            begin
               tmr_nxt = {`STO_CNT_W{1'b0}};
               if (held_r || tmr_r >= OPEN_DET_CYC)
                  state_nxt = ST_DEAD; // see (RULE2)
               else
                  state_nxt = ST_CLOSED;
            end
         end
         ST_DEAD:
         begin
            // Switch activity is not looked at here.
            if (tmr_r >= DEAD_CYC - 1'b1)
            begin
               state_nxt = ST_MOTOR; // see (RULE3) (RULE11)
               tmr_nxt   = {`STO_CNT_W{1'b0}};
            end
         end
         ST_MOTOR:
         begin
            if (tmr_r >= MOTOR_CYC - 1'b1)
            begin
               state_nxt = ST_GUARD; // see (RULE11)
               tmr_nxt   = {`STO_CNT_W{1'b0}};
            end
         end
         ST_GUARD:
         begin
            // Timer runs only while the switch is inactive; an active switch holds it cleared.
            if (sw_deb_r)
               tmr_nxt = {`STO_CNT_W{1'b0}}; // see (RULE8) (RULE11)
            else if (sw_fall)
               tmr_nxt = {`STO_CNT_W{1'b0}}; // see (RULE6) (RULE9)
            else if (tmr_r >= CLOSED_DET_CYC - 1'b1)
            begin
               state_nxt = ST_CLOSED; // see (RULE7)
               tmr_nxt   = {`STO_CNT_W{1'b0}};
            end
         end
         default:
         begin
            state_nxt = ST_CLOSED;
            tmr_nxt   = {`STO_CNT_W{1'b0}};
            held_nxt  = 1'b0;
         end
      endcase
   end

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r      <= ST_CLOSED;
         tmr_r        <= {`STO_CNT_W{1'b0}}; // see (RULE10)
         held_r       <= 1'b0;
      end
      else
      begin
         state_r      <= state_nxt;
         tmr_r        <= tmr_nxt;
         held_r       <= held_nxt;
      end
   end

   // Motor and ready outputs are decoded from the next phase so they line up with the phase register.
   always @*
   begin
      motor_act_nxt  = 1'b0;
      open_ready_nxt = 1'b0;
      case (state_nxt)
         ST_CLOSED:
            open_ready_nxt = 1'b1;
         ST_HOLD:
            open_ready_nxt = 1'b1;
         ST_MOTOR:
            motor_act_nxt = 1'b1; // see (RULE3)
         default:
         begin
            motor_act_nxt  = 1'b0;
            open_ready_nxt = 1'b0; // see (RULE11)
         end
      endcase
   end

   // Registered outputs keep decode glitches away from the motor driver.
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         motor_act_r  <= 1'b0;
         app_open_r   <= 1'b0;
         open_ready_r <= 1'b0;
      end
      else
      begin
         motor_act_r  <= motor_act_nxt;
         app_open_r   <= sw_deb_r; // see (RULE5)
         open_ready_r <= open_ready_nxt;
      end
   end

endmodule

// ==== design/sto_map.vh ====
// Timing constants for the soft-touch open sequencer.
`ifndef STO_MAP_VH
`define STO_MAP_VH
`define STO_CLK_KHZ         10000
`define STO_DEB_MS          20
`define STO_DEB_CYC         (`STO_DEB_MS * `STO_CLK_KHZ)
`define STO_REACT_MAX_MS    70
`define STO_OPEN_DET_MS     300
`define STO_OPEN_DET_CYC    (`STO_OPEN_DET_MS * `STO_CLK_KHZ)
`define STO_CLOSED_DET_MS   1000
`define STO_CLOSED_DET_CYC  (`STO_CLOSED_DET_MS * `STO_CLK_KHZ)
`define STO_DEAD_MS         100
`define STO_DEAD_CYC        (`STO_DEAD_MS * `STO_CLK_KHZ)
`define STO_MOTOR_MS        500
`define STO_MOTOR_CYC       (`STO_MOTOR_MS * `STO_CLK_KHZ)
`define STO_CNT_W           24
`endif

// ==== verif/sto_chk_assertions.sv ====
// Assertions for the soft-touch open sequencer.
`timescale 1ns/1ps
module sto_chk (
   input wire clk,
   input wire rst_b,
   input wire switch_in,
   input wire motor_act_r,
   input wire app_open_r,
   input wire open_ready_r
);
   reg [7:0] hold_r;
   reg [7:0] last_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_mot;
      motor_act_r[*6] ##1 !motor_act_r;
   endsequence
   // Length of the last open phase, so a release can be judged after it.
   always @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         hold_r <= 8'h00;
         last_r <= 8'h00;
      end
      else
      begin
         hold_r <= app_open_r ? hold_r + 8'h01 : 8'h00;
         if (!app_open_r && hold_r != 8'h00)
            last_r <= hold_r;
      end
   AST_RST: assert property ($rose(rst_b) |-> !motor_act_r && !app_open_r && !open_ready_r)
      else $error("outputs not clear after reset");
   AST_FOLLOW: assert property ($rose(app_open_r) |-> $past(switch_in, 3) && $past(switch_in, 5))
      else $error("open flag without a held switch");
   AST_HOLD: assert property ($rose(motor_act_r) |-> last_r >= 8'h0b)
      else $error("motor after a short hold");
   AST_DEAD: assert property ($fell(app_open_r) |-> !motor_act_r[*8])
      else $error("motor inside the dead time");
   AST_LEN: assert property ($rose(motor_act_r) |-> s_mot)
      else $error("motor pulse length wrong");
   AST_BUSY: assert property (motor_act_r |-> !open_ready_r)
      else $error("ready while motor runs");
   AST_GUARD: assert property ($fell(motor_act_r) |-> !open_ready_r[*8])
      else $error("ready before closed guard");
   AST_RDY: assert property ($rose(open_ready_r) |-> !app_open_r)
      else $error("ready while open");
endmodule
bind sto_sequencer sto_chk u_chk (.clk(clk), .rst_b(rst_b), .switch_in(switch_in),
   .motor_act_r(motor_act_r), .app_open_r(app_open_r), .open_ready_r(open_ready_r));

// ==== verif/sto_operator.sv ====
// Operator push switch model.
`timescale 1ns/1ps
module sto_operator (
   input  wire clk,
   input  wire want,
   output reg  sw
);
   initial sw = 1'b0;
   always @(posedge clk)
      sw <= want;
endmodule

// ==== verif/tb_top.sv ====
// Self-checking testbench for the soft-touch open sequencer.
`timescale 1ns/1ps
module tb_top;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg want = 1'b0;
   reg m = 1'b0;
   reg [8:0] rows [0:2];
   wire sw, mot, opn, rdy;
   integer n_fail = 0, n_tests = 0, cyc = 0, i = 0, t = 0;
   always #50 clk = ~clk;
   sto_operator u_op (.clk(clk), .want(want), .sw(sw));
   sto_sequencer #(.DEB_CYC(24'h4), .OPEN_DET_CYC(24'ha), .CLOSED_DET_CYC(24'h14),
      .DEAD_CYC(24'h8), .MOTOR_CYC(24'h6)) dut (.clk(clk), .rst_b(rst_b),
      .switch_in(sw), .motor_act_r(mot), .app_open_r(opn), .open_ready_r(rdy));
   task close_out;
   begin
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task tick;
   begin
      @(posedge clk);
      #1;
   end
   endtask
   // Hold the switch n cycles, release, then count cycles until the motor starts.
   task press(input [7:0] n);
   begin
      @(posedge clk) want <= 1'b1;
      repeat (n) @(posedge clk);
      want <= 1'b0;
      for (t = 0; t < 40 && mot !== 1'b1; t = t + 1)
         tick;
   end
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail = n_fail + 1;
         close_out;
      end
   end
   initial
   begin
      rows[0] = {1'b0, 8'h06};
      rows[1] = {1'b1, 8'h10};
      rows[2] = {1'b1, 8'h1e};
      repeat (6) @(posedge clk);
      chk({5'h0, mot, opn, rdy}, 8'h00);
      rst_b <= 1'b1;
      tick;
      chk({5'h0, mot, opn, rdy}, 8'h01);
      $display("reset test done");
      for (i = 0; i < 3; i = i + 1)
      begin
         press(rows[i][7:0]);
         chk((t >= 8 && t <= 20) ? 8'h01 : (t < 40 ? 8'h02 : 8'h00), {7'h0, rows[i][8]});
         for (t = 0; t < 80 && rdy !== 1'b1; t = t + 1)
            tick;
         chk({7'h0, rdy}, 8'h01);
         $display("row %0d done", i);
      end
      // A full press during the closed guard clears it and must not open.
      press(8'h10);
      for (t = 0; t < 20 && mot === 1'b1; t = t + 1)
         tick;
      @(posedge clk) want <= 1'b1;
      repeat (12) @(posedge clk);
      want <= 1'b0;
      for (t = 0; t < 60 && rdy !== 1'b1; t = t + 1)
      begin
         tick;
         m = m | mot;
      end
      chk({6'h0, m, (t >= 23 && t <= 36)}, 8'h01);
      $display("guard test done");
      close_out;
   end
endmodule
